// ---- rtl/tmd_pkg.sv ----
// Behaviour
// RL1: In interval mode the timer event is raised only when interval_irq_enable (bit 15) is 1; reset leaves it 0.
// RL2: With match_zero_clear_enable (bit 0) set, the counter returns to zero on reaching compare A.
// RL3: With match_zero_clear_enable clear, the counter halts and holds at compare A after a match.
// RL4: While halted at compare A without zero clear, no further interval event is raised.
// RL5: The selected count clock is divided by 2 to the power (n+1), n being bits 2:0; reset selects 000.
// RL6: The divisor applies to whichever count clock source is currently selected.
// RL7: In pulse mode a compare B match raises the event only when pulse_match_b_irq_enable (bit 15) is 1.
// RL8: In pulse mode a compare A match raises the event only when pulse_match_a_irq_enable (bit 14) is 1.
// RL9: The pulse output flip-flop is loaded with output_initial_level (bit 0), reset value 0.
// RL10: Pulse generator settings exist only for timers 1 and 2, not timer 0.
// RL11: The 2-bit mode field selects 00 interval, 01 pulse, 10 watchdog, 11 reserved.
// RL12: The divided clock is used only when prescale_enable is 1, otherwise the undivided source.
// RL13: Division is a synchronous prescaler giving a one-cycle count enable on the single clock.
package tmd_pkg;

  // Register offsets within one timer's window
  localparam logic [7:0] TMD_OFS_INTERVAL = 8'h10;
  localparam logic [7:0] TMD_OFS_DIVIDE   = 8'h20;
  localparam logic [7:0] TMD_OFS_PULSE    = 8'h30;

  // Field positions
  localparam int TMD_BIT_IIE     = 15;
  localparam int TMD_BIT_ZCE     = 0;
  localparam int TMD_BIT_PBE     = 15;
  localparam int TMD_BIT_PAE     = 14;
  localparam int TMD_BIT_INIT    = 0;
  localparam int TMD_DIV_MSB     = 2;
  localparam int TMD_DIV_W       = 3;

  // Reset values
  localparam logic       TMD_RST_BIT = 1'b0;
  localparam logic [2:0] TMD_RST_DIV = 3'h0;

  // Prescaler width: largest divisor is 256
  localparam int TMD_PRE_W = 8;

  // Operating modes
  typedef enum logic [1:0] {
    TMD_MODE_INTERVAL = 2'h0,
    TMD_MODE_PULSE    = 2'h1,
    TMD_MODE_WATCHDOG = 2'h2,
    TMD_MODE_RSVD     = 2'h3
  } tmd_mode_t;

  // Settings held by the control register outside this block
  typedef struct packed {
    tmd_mode_t mode;         // operating_mode_select
    logic      count_en;     // counter running
    logic      clear_stop;   // clear count while stopped
    logic      prescale_en;  // prescale_enable
    logic      src_ext;      // 1: external count clock
    logic      ext_rise;     // 1: count on rising external edge
  } tmd_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tmd_req_t;

endpackage : tmd_pkg

// ---- rtl/tmd_timer_cfg.sv ----
`timescale 1ns/100ps
module tmd_timer_cfg
  import tmd_pkg::*;
#(
  parameter int CHAN  = 1,   // timer index 0..2
  parameter int CNT_W = 32   // counter width
) (
  input  wire logic             clk,         // 50 MHz bus clock
  input  wire logic             rst,         // async reset, high
  input  wire tmd_req_t         req,         // register access
  output logic [31:0]           rdata,       // read data, registered
  input  wire tmd_ctrl_t        ctrl,        // control settings
  input  wire logic [CNT_W-1:0] compare_value_a, // compare A
  input  wire logic [CNT_W-1:0] compare_value_b, // compare B
  input  wire logic             ext_clk_in,  // external count clock
  output logic [CNT_W-1:0]      count,       // counter value
  output logic                  pulse_out,   // pulse output flip-flop
  output logic                  irq_event    // one-cycle timer event
);

  localparam logic HAS_PG = (CHAN != 0);

  // Configuration registers
  logic                 interval_irq_enable_r;
  logic                 match_zero_clear_enable_r;
  logic [TMD_DIV_W-1:0] clock_divide_select_r;
  logic                 pulse_match_b_irq_enable_r;
  logic                 pulse_match_a_irq_enable_r;
  logic                 output_initial_level_r;

  // Datapath state
  logic [TMD_PRE_W-1:0] pre_r;
  logic [CNT_W-1:0]     count_r;
  logic                 halted_r;
  logic                 pulse_r;
  logic                 ext_prev_r;
  logic                 event_r;
  logic [31:0]          rdata_r;

  logic                 src_tick;
  logic                 div_tick;
  logic                 cnt_tick;
  logic                 match_a;
  logic                 match_b;
  logic                 int_event;
  logic                 pg_a_event;
  logic                 pg_b_event;
  logic [TMD_PRE_W-1:0] pre_last;

  // Address decode helper
  function automatic logic hit(input tmd_req_t r, input logic [7:0] ofs);
    hit = (r.addr == ofs);
  endfunction : hit

  // Interval mode register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interval_irq_enable_r     <= TMD_RST_BIT; // RL1
      match_zero_clear_enable_r <= TMD_RST_BIT;
    end else if (req.wr && hit(req, TMD_OFS_INTERVAL)) begin
      interval_irq_enable_r     <= req.wdata[TMD_BIT_IIE];
      match_zero_clear_enable_r <= req.wdata[TMD_BIT_ZCE];
    end
  end

  // Divide register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clock_divide_select_r <= TMD_RST_DIV; // RL5
    end else if (req.wr && hit(req, TMD_OFS_DIVIDE)) begin
      clock_divide_select_r <= req.wdata[TMD_DIV_MSB:0];
    end
  end

  // Pulse mode register write, absent on timer 0
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_match_b_irq_enable_r <= TMD_RST_BIT; // RL7
      pulse_match_a_irq_enable_r <= TMD_RST_BIT; // RL8
      output_initial_level_r     <= TMD_RST_BIT; // RL9
    end else if (HAS_PG && req.wr && hit(req, TMD_OFS_PULSE)) begin // RL10
      pulse_match_b_irq_enable_r <= req.wdata[TMD_BIT_PBE];
      pulse_match_a_irq_enable_r <= req.wdata[TMD_BIT_PAE];
      output_initial_level_r     <= req.wdata[TMD_BIT_INIT];
    end
  end

  // Register read, unmapped offsets read zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0;
    end else if (req.rd) begin
      rdata_r <= 32'h0;
      if (hit(req, TMD_OFS_INTERVAL)) begin
        rdata_r[TMD_BIT_IIE] <= interval_irq_enable_r;
        rdata_r[TMD_BIT_ZCE] <= match_zero_clear_enable_r;
      end else if (hit(req, TMD_OFS_DIVIDE)) begin
        rdata_r[TMD_DIV_MSB:0] <= clock_divide_select_r;
      end else if (HAS_PG && hit(req, TMD_OFS_PULSE)) begin // RL10
        rdata_r[TMD_BIT_PBE]  <= pulse_match_b_irq_enable_r;
        rdata_r[TMD_BIT_PAE]  <= pulse_match_a_irq_enable_r;
        rdata_r[TMD_BIT_INIT] <= output_initial_level_r;
      end
    end
  end

  // External clock edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_clk_in;
    end
  end

  // Source tick from the selected count clock
  always_comb begin
    if (ctrl.src_ext) begin
      src_tick = ctrl.ext_rise ? (ext_clk_in & ~ext_prev_r)
                               : (~ext_clk_in & ext_prev_r);
    end else begin
      src_tick = 1'b1;
    end
  end

  // Last prescaler value: 2^(n+1)-1
  assign pre_last = TMD_PRE_W'((16'h2 << clock_divide_select_r) - 16'h1); // RL5

  // Prescaler counts source ticks only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
    end else if (!ctrl.count_en || !ctrl.prescale_en) begin
      pre_r <= '0;
    end else if (src_tick) begin // RL6
      pre_r <= (pre_r >= pre_last) ? '0 : pre_r + 1'b1; // RL13
    end
  end

  // One-cycle count enable
  assign div_tick = src_tick && (pre_r >= pre_last); // RL13
  assign cnt_tick = ctrl.count_en && (ctrl.prescale_en ? div_tick : src_tick); // RL12

  assign match_a = (count_r == compare_value_a);
  assign match_b = (count_r == compare_value_b);

  // Match events per mode
  assign int_event  = (ctrl.mode == TMD_MODE_INTERVAL) && cnt_tick && match_a && !halted_r; // RL4
  assign pg_a_event = (ctrl.mode == TMD_MODE_PULSE) && HAS_PG && cnt_tick && match_a;
  assign pg_b_event = (ctrl.mode == TMD_MODE_PULSE) && HAS_PG && cnt_tick && match_b;

  // Counter and halt state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r  <= '0;
      halted_r <= 1'b0;
    end else if (!ctrl.count_en) begin
      if (ctrl.clear_stop) begin
        count_r  <= '0;
        halted_r <= 1'b0;
      end
    end else if (ctrl.mode == TMD_MODE_RSVD) begin
      halted_r <= halted_r;
    end else if (int_event) begin
      if (match_zero_clear_enable_r) begin
        count_r <= '0; // RL2
      end else begin
        halted_r <= 1'b1; // RL3
      end
    end else if (pg_b_event) begin
      count_r <= '0;
    end else if (cnt_tick && !halted_r) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Pulse output flip-flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_r <= TMD_RST_BIT;
    end else if (!HAS_PG || ctrl.mode != TMD_MODE_PULSE || !ctrl.count_en) begin // RL11
      pulse_r <= output_initial_level_r; // RL9
    end else if (pg_a_event ^ pg_b_event) begin
      pulse_r <= ~pulse_r;
    end
  end

  // Gated timer event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      event_r <= 1'b0;
    end else begin
      event_r <= (int_event && interval_irq_enable_r)        // RL1
               | (pg_b_event && pulse_match_b_irq_enable_r)  // RL7
               | (pg_a_event && pulse_match_a_irq_enable_r); // RL8
    end
  end

  // Outputs
  assign rdata     = rdata_r;
  assign count     = count_r;
  assign pulse_out = pulse_r;
  assign irq_event = event_r;

endmodule : tmd_timer_cfg

// ---- tb/tb_tmd_timer_cfg.sv ----
`timescale 1ns/100ps
module tb_tmd_timer_cfg;
  import tmd_pkg::*;
  logic clk, rst, ext, pout, irq;
  tmd_req_t req;
  tmd_ctrl_t ctrl;
  logic [31:0] cva, cvb, rdata, rdata0, cnt;
  int fails, checks_done, e, t;
  tmd_timer_cfg #(.CHAN(1)) uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .ctrl(ctrl), .compare_value_a(cva),
    .compare_value_b(cvb), .ext_clk_in(ext), .count(cnt), .pulse_out(pout), .irq_event(irq));
  tmd_timer_cfg #(.CHAN(0)) uut0 (.clk(clk), .rst(rst), .req(req), .rdata(rdata0), .ctrl(ctrl),
    .compare_value_a(cva), .compare_value_b(cvb), .ext_clk_in(ext), .count(), .pulse_out(), .irq_event());
  // Clock and external count clock
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    ext = 0;
    forever begin repeat (3) @(posedge clk); #1 ext = ~ext; end
  end
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin $display("wrong value %s exp %h got %h", n, x, g); fails++; end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk); #1 req.wr = 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] x);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk); #1 req.rd = 0;
    chk("rdata", x, rdata);
    chk("rdata0", a == TMD_OFS_PULSE ? 32'h0 : x, rdata0);
  endtask : rd
  // Counts events and pulse output toggles over n cycles
  task run_cycles(input int n);
    logic pv;
    e = 0;
    t = 0;
    pv = pout;
    repeat (n) begin
      @(posedge clk);
      #1 if (irq === 1'b1) e++;
      if (pout !== pv) t++;
      pv = pout;
    end
  endtask : run_cycles
  task gap(input int x);
    logic [31:0] c;
    int k;
    for (int p = 0; p < 2; p++) begin
      c = cnt; k = 0;
      while (cnt === c && k < 600) begin @(posedge clk); #1 k++; end
      if (k >= 600) begin fails++; complete_run; end
    end
    chk("tick gap", x, k);
  endtask : gap
  // Main sequence
  initial begin
    logic [7:0] ofs[4] = '{8'h10, 8'h20, 8'h30, 8'h44};
    logic [31:0] msk[4] = '{32'h8001, 32'h7, 32'hc001, 32'h0};
    tmd_mode_t md[7] = '{TMD_MODE_INTERVAL, TMD_MODE_INTERVAL, TMD_MODE_PULSE, TMD_MODE_PULSE,
      TMD_MODE_PULSE, TMD_MODE_WATCHDOG, TMD_MODE_INTERVAL};
    logic [31:0] ir[7] = '{32'h8001, 32'h1, 32'h0, 32'h0, 32'h8001, 32'h8001, 32'h8000};
    logic [31:0] pr[7] = '{32'h0, 32'h0, 32'h4000, 32'h8000, 32'h1, 32'hc000, 32'h0};
    int ex[7] = '{6, 0, 4, 4, 0, 0, 0};
    int tg[7] = '{0, 0, 8, 8, 8, 0, 0};
    rst = 1; req = '0; ctrl = '0; cva = 32'h3; cvb = 32'h5; fails = 0; checks_done = 0;
    repeat (10) @(posedge clk);
    #1 rst = 0;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++) begin
        if (p) wr(ofs[i], 32'hffffffff);
        rd(ofs[i], p ? msk[i] : 32'h0);
      end
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      ctrl.count_en = 0; ctrl.clear_stop = 1;
      wr(TMD_OFS_INTERVAL, ir[i]);
      wr(TMD_OFS_PULSE, pr[i]);
      @(posedge clk);
      #1 chk("initial level", pr[i][0], pout);
      ctrl.mode = md[i]; ctrl.count_en = 1;
      run_cycles(8);
      run_cycles(24);
      chk("events", ex[i], e);
      chk("toggles", tg[i], t);
    end
    chk("held count", 32'h3, cnt);
    $display("test events done");
    ctrl.count_en = 0; cva = 32'hffffffff;
    @(posedge clk); #1 ctrl.count_en = 1;
    gap(1);
    ctrl.prescale_en = 1;
    for (int n = 0; n < 8; n++) begin
      wr(TMD_OFS_DIVIDE, n);
      gap(2 << n);
    end
    wr(TMD_OFS_DIVIDE, 32'h1);
    ctrl.src_ext = 1; ctrl.ext_rise = 1;
    gap(24);
    $display("test divider done");
    rst = 1;
    @(posedge clk);
    #1 chk("reset count", 32'h0, cnt);
    rst = 0;
    rd(TMD_OFS_DIVIDE, 32'h0);
    $display("test reset done");
    complete_run;
  end
endmodule : tb_tmd_timer_cfg
bind tmd_timer_cfg tmd_cfg_checker #(.CHAN(CHAN), .CNT_W(CNT_W)) chk_i (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
  .ctrl(ctrl), .compare_value_a(compare_value_a), .compare_value_b(compare_value_b), .count(count),
  .pulse_out(pulse_out), .irq_event(irq_event));

// ---- tb/tmd_cfg_checker.sv ----
`timescale 1ns/100ps
module tmd_cfg_checker
  import tmd_pkg::*;
#(parameter int CHAN = 1, parameter int CNT_W = 32) (
  input wire logic             clk,             // clock
  input wire logic             rst,             // reset
  input wire tmd_req_t         req,             // bus request
  input wire logic [31:0]      rdata,           // read data
  input wire tmd_ctrl_t        ctrl,            // control
  input wire logic [CNT_W-1:0] compare_value_a, // compare A
  input wire logic [CNT_W-1:0] compare_value_b, // compare B
  input wire logic [CNT_W-1:0] count,           // counter
  input wire logic             pulse_out,       // pulse flop
  input wire logic             irq_event        // event pulse
);
  logic iie_r, zce_r, pbe_r, pae_r, ini_r;
  logic intv, raw;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the enable bits and the initial level bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {iie_r, zce_r, pbe_r, pae_r, ini_r} <= '0;
    else if (req.wr && req.addr == TMD_OFS_INTERVAL) {iie_r, zce_r} <= {req.wdata[15], req.wdata[0]};
    else if (req.wr && req.addr == TMD_OFS_PULSE && CHAN != 0) {pbe_r, pae_r, ini_r} <= {req.wdata[15:14], req.wdata[0]};
  end
  // Interval mode running on the raw clock
  assign intv = ctrl.mode == TMD_MODE_INTERVAL && ctrl.count_en;
  assign raw  = !ctrl.prescale_en && !ctrl.src_ext;
  int_mask_a: assert property (irq_event && $past(ctrl.mode) == TMD_MODE_INTERVAL |-> $past(iie_r)) else $error("event while masked");
  zero_clr_a: assert property (intv && raw && zce_r && count == compare_value_a |=> count == '0) else $error("no zero clear");
  halt_hold_a: assert property (intv && !zce_r && count == compare_value_a |=> count == $past(count)) else $error("halt lost");
  halt_quiet_a: assert property (irq_event && $past(ctrl.mode) == TMD_MODE_INTERVAL && !zce_r |=> !irq_event [*8]) else $error("event recurred");
  raw_rate_a: assert property (intv && raw && count != compare_value_a |=> count == $past(count) + 1'b1) else $error("raw count");
  pulse_gate_a: assert property (irq_event && $past(ctrl.mode) == TMD_MODE_PULSE |->
    $past(pae_r && count == compare_value_a || pbe_r && count == compare_value_b)) else $error("pulse event");
  init_lvl_a: assert property (!ctrl.count_en |=> pulse_out == $past(ini_r)) else $error("initial level");
  wdog_quiet_a: assert property (irq_event |-> $past(ctrl.mode) != TMD_MODE_WATCHDOG) else $error("watchdog event");
  pulse_rd_a: assert property (req.rd && req.addr == TMD_OFS_PULSE |=>
    rdata == (CHAN == 0 ? 32'h0 : {16'h0, $past(pbe_r), $past(pae_r), 13'h0, $past(ini_r)})) else $error("pulse read");
endmodule : tmd_cfg_checker
